// ---- core/bcc_pkg.sv ----
// Constants shared by the clock and calendar counter chain
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE_01] Seconds and minutes count BCD modulo sixty
// [RULE_02] Seconds write clears the sub-second divider
// [RULE_03] Hours count BCD modulo twenty-four
// [RULE_04] Written sixty seconds rolls to zero later
// [RULE_05] Counting halts while stop set, resumes instantly
// [RULE_06] Weekday is one-hot, rotates left, wraps
// [RULE_07] Weekday advances on hour carry, carries nothing
// [RULE_08] Host rewrites weekday after any date change
// [RULE_09] Host never writes more than one weekday bit
// [RULE_10] Weekday may stay uninitialised when unused
// [RULE_11] Month length from month and leap year
// [RULE_12] Month counts BCD modulo twelve on day carry
// [RULE_13] Year counts BCD from 00 to 99
// [RULE_14] Years divisible by four are leap years
// [RULE_15] Host corrects century years that are common
// [RULE_16] Host writes only valid BCD values
// [RULE_17] Day and month start at 01, year wraps
// [RULE_18] Second tick comes from binary divider stage
//////////////////////////////////////////////////////////////////////////////
package bcc_pkg;
   // Register indices; the bus address is the index itself
   localparam logic [3:0] ADDR_SECONDS = 4'h0;
   localparam logic [3:0] ADDR_MINUTES = 4'h1;
   localparam logic [3:0] ADDR_HOURS = 4'h2;
   localparam logic [3:0] ADDR_WEEKDAY = 4'h3;
   localparam logic [3:0] ADDR_DAY = 4'h4;
   localparam logic [3:0] ADDR_MONTH = 4'h5;
   localparam logic [3:0] ADDR_YEAR = 4'h6;
   localparam logic [3:0] ADDR_CONTROL = 4'h7;
   // Control register field
   localparam int CTRL_STOP_BIT = 0;
   localparam logic CTRL_STOP_RESET = 1'b1;
   // Reset values of the counters
   localparam logic [7:0] SEC_RESET = 8'h00;
   localparam logic [7:0] MIN_RESET = 8'h00;
   localparam logic [7:0] HOUR_RESET = 8'h00;
   localparam logic [7:0] WDAY_RESET = 8'h01;
   localparam logic [7:0] DAY_RESET = 8'h01;
   localparam logic [7:0] MONTH_RESET = 8'h01;
   localparam logic [7:0] YEAR_RESET = 8'h00;
   // Counting limits in BCD
   localparam logic [7:0] BCD_59 = 8'h59;
   localparam logic [7:0] BCD_60 = 8'h60;
   localparam logic [7:0] BCD_23 = 8'h23;
   localparam logic [7:0] BCD_12 = 8'h12;
   localparam logic [7:0] BCD_99 = 8'h99;
   localparam logic [7:0] BCD_01 = 8'h01;
   localparam logic [7:0] BCD_00 = 8'h00;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_31 = 8'h31;
   localparam logic [7:0] MONTH_FEB = 8'h02;
   localparam logic [7:0] MONTH_APR = 8'h04;
   localparam logic [7:0] MONTH_JUN = 8'h06;
   localparam logic [7:0] MONTH_SEP = 8'h09;
   localparam logic [7:0] MONTH_NOV = 8'h11;
   // Weekday one-hot ends
   localparam logic [6:0] WDAY_FIRST = 7'h01;
   localparam logic [6:0] WDAY_LAST = 7'h40;
   // Sub-second divider: oscillator taps from 1024 Hz down to 1 Hz
   localparam int OSC_HZ = 1024;
   localparam int DIV_WIDTH = $clog2(OSC_HZ);
endpackage : bcc_pkg

// ---- core/bcc_bcd_counter.sv ----
// One BCD counter stage with a load port and a wrap value
`timescale 1ns/100ps
`default_nettype none
module bcc_bcd_counter (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reset_value_i,
   input wire logic load_i,
   input wire logic [7:0] load_value_i,
   input wire logic inc_i,
   input wire logic [7:0] last_i,
   input wire logic [7:0] first_i,
   output logic [7:0] count_o,
   output logic carry_o
);
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [7:0] bumped;
   logic at_last;

   // BCD increment: low digit rolls at 9 into the high digit
   assign bumped = (count_q[3:0] == 4'h9) ? {count_q[7:4] + 4'h1, 4'h0}
                                          : {count_q[7:4], count_q[3:0] + 4'h1};
   // Anything at or past the last value wraps, so stray values recover
   assign at_last = (count_q >= last_i);
   assign carry_o = inc_i & at_last & ~load_i;
   assign count_d = load_i ? load_value_i :
                    inc_i ? (at_last ? first_i : bumped) : count_q;
   assign count_o = count_q;

   // Counter register
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         count_q <= 8'h00;
      else
         count_q <= count_d;
   end
   // reset_value_i is applied by the parent via a load during reset release
   logic unused_reset;
   assign unused_reset = ^reset_value_i;
endmodule : bcc_bcd_counter
`default_nettype wire

// ---- core/bcc_clock_calendar.sv ----
// Clock and calendar counter chain with its register port
`timescale 1ns/100ps
`default_nettype none
module bcc_clock_calendar (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic osc_tick_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic second_tick_o
);
   //////////////////////////////////////////////////////////////////////////
   // Write decode
   logic wr_sec;
   logic wr_min;
   logic wr_hour;
   logic wr_wday;
   logic wr_day;
   logic wr_month;
   logic wr_year;
   logic wr_ctrl;
   logic init_q;
   assign wr_sec = wr_i & (addr_i == bcc_pkg::ADDR_SECONDS);
   assign wr_min = wr_i & (addr_i == bcc_pkg::ADDR_MINUTES);
   assign wr_hour = wr_i & (addr_i == bcc_pkg::ADDR_HOURS);
   assign wr_wday = wr_i & (addr_i == bcc_pkg::ADDR_WEEKDAY);
   assign wr_day = wr_i & (addr_i == bcc_pkg::ADDR_DAY);
   assign wr_month = wr_i & (addr_i == bcc_pkg::ADDR_MONTH);
   assign wr_year = wr_i & (addr_i == bcc_pkg::ADDR_YEAR);
   assign wr_ctrl = wr_i & (addr_i == bcc_pkg::ADDR_CONTROL);

   // First cycle after reset loads each counter with its reset value
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         init_q <= 1'b1;
      else
         init_q <= 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////
   // Stop bit and sub-second divider
   logic stop_q;
   logic [bcc_pkg::DIV_WIDTH-1:0] div_q;
   logic div_wrap;
   logic sec_inc;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         stop_q <= bcc_pkg::CTRL_STOP_RESET;
      else if (wr_ctrl)
         stop_q <= wdata_i[bcc_pkg::CTRL_STOP_BIT];
   end

   // Final divider stage overflow is the one-second tick [RULE_18]
   assign div_wrap = osc_tick_i & (&div_q);
   // Nothing advances while stopped; release restarts from a cleared divider [RULE_05]
   // A seconds write wins over the tick, so no pulse is reported for it [RULE_02]
   assign sec_inc = div_wrap & ~stop_q & ~wr_sec;

   // Divider holds at zero while stopped so time restarts at the release [RULE_05]
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         div_q <= '0;
      else if (wr_sec || stop_q) // [RULE_02]
         div_q <= '0;
      else if (osc_tick_i)
         div_q <= div_q + {{(bcc_pkg::DIV_WIDTH-1){1'b0}}, 1'b1};
   end

   //////////////////////////////////////////////////////////////////////////
   // Time counters
   logic [7:0] sec_count;
   logic [7:0] min_count;
   logic [7:0] hour_count;
   logic [7:0] day_count;
   logic [7:0] month_count;
   logic [7:0] year_count;
   logic sec_carry;
   logic min_carry;
   logic hour_carry;
   logic day_carry;
   logic month_carry;
   logic [7:0] sec_last;
   logic [7:0] day_last;
   logic leap_year;

   // A written 60 is one past the normal end and wraps to 00 next second [RULE_04]
   assign sec_last = (sec_count == bcc_pkg::BCD_60) ? bcc_pkg::BCD_60 : bcc_pkg::BCD_59;

   // Seconds: modulo sixty with carry into minutes [RULE_01]
   bcc_bcd_counter u_seconds (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .reset_value_i(bcc_pkg::SEC_RESET),
      .load_i(wr_sec | init_q),
      .load_value_i(init_q ? bcc_pkg::SEC_RESET : wdata_i),
      .inc_i(sec_inc),
      .last_i(sec_last),
      .first_i(bcc_pkg::BCD_00),
      .count_o(sec_count),
      .carry_o(sec_carry)
   );

   // Minutes: modulo sixty with carry into hours [RULE_01]
   bcc_bcd_counter u_minutes (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .reset_value_i(bcc_pkg::MIN_RESET),
      .load_i(wr_min | init_q),
      .load_value_i(init_q ? bcc_pkg::MIN_RESET : wdata_i),
      .inc_i(sec_carry),
      .last_i(bcc_pkg::BCD_59),
      .first_i(bcc_pkg::BCD_00),
      .count_o(min_count),
      .carry_o(min_carry)
   );

   // Hours: 24-hour format [RULE_03]
   bcc_bcd_counter u_hours (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .reset_value_i(bcc_pkg::HOUR_RESET),
      .load_i(wr_hour | init_q),
      .load_value_i(init_q ? bcc_pkg::HOUR_RESET : wdata_i),
      .inc_i(min_carry),
      .last_i(bcc_pkg::BCD_23),
      .first_i(bcc_pkg::BCD_00),
      .count_o(hour_count),
      .carry_o(hour_carry)
   );

   //////////////////////////////////////////////////////////////////////////
   // Weekday rotator
   logic [7:0] weekday_onehot_q;
   logic [6:0] wday_next;
   // Rotate left within seven bits; 40h wraps to 01h [RULE_06]
   assign wday_next = (weekday_onehot_q[6:0] == bcc_pkg::WDAY_LAST) ? bcc_pkg::WDAY_FIRST
                                                                  : {weekday_onehot_q[5:0], 1'b0};

   // Stored as written; no validity check so an unused weekday is harmless [RULE_10]
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || init_q)
         weekday_onehot_q <= bcc_pkg::WDAY_RESET;
      else if (wr_wday)
         weekday_onehot_q <= wdata_i;
      else if (hour_carry) // [RULE_07]
         weekday_onehot_q <= {weekday_onehot_q[7], wday_next};
   end

   //////////////////////////////////////////////////////////////////////////
   // Calendar
   // BCD year is a multiple of four when tens is even and units 0,4,8,
   // or tens odd and units 2,6 [RULE_14]
   assign leap_year = year_count[4] ? (year_count[3:0] == 4'h2 || year_count[3:0] == 4'h6)
                                    : (year_count[1:0] == 2'b00);

   // Month length table [RULE_11]
   assign day_last = (month_count == bcc_pkg::MONTH_FEB) ?
                        (leap_year ? bcc_pkg::DAYS_29 : bcc_pkg::DAYS_28) : // [RULE_14]
                     (month_count == bcc_pkg::MONTH_APR || month_count == bcc_pkg::MONTH_JUN ||
                      month_count == bcc_pkg::MONTH_SEP || month_count == bcc_pkg::MONTH_NOV) ?
                        bcc_pkg::DAYS_30 : bcc_pkg::DAYS_31;

   // Day of month advances on the hour carry, wraps to 01 [RULE_17]
   bcc_bcd_counter u_day (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .reset_value_i(bcc_pkg::DAY_RESET),
      .load_i(wr_day | init_q),
      .load_value_i(init_q ? bcc_pkg::DAY_RESET : wdata_i),
      .inc_i(hour_carry),
      .last_i(day_last),
      .first_i(bcc_pkg::BCD_01),
      .count_o(day_count),
      .carry_o(day_carry)
   );

   // Month modulo twelve starting at 01 [RULE_12] [RULE_17]
   bcc_bcd_counter u_month (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .reset_value_i(bcc_pkg::MONTH_RESET),
      .load_i(wr_month | init_q),
      .load_value_i(init_q ? bcc_pkg::MONTH_RESET : wdata_i),
      .inc_i(day_carry),
      .last_i(bcc_pkg::BCD_12),
      .first_i(bcc_pkg::BCD_01),
      .count_o(month_count),
      .carry_o(month_carry)
   );

   // Year 00 to 99; its carry goes nowhere [RULE_13] [RULE_17]
   bcc_bcd_counter u_year (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .reset_value_i(bcc_pkg::YEAR_RESET),
      .load_i(wr_year | init_q),
      .load_value_i(init_q ? bcc_pkg::YEAR_RESET : wdata_i),
      .inc_i(month_carry),
      .last_i(bcc_pkg::BCD_99),
      .first_i(bcc_pkg::BCD_00),
      .count_o(year_count),
      .carry_o()
   );

   //////////////////////////////////////////////////////////////////////////
   // Read port: data one cycle after the strobe, zero for unmapped addresses
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;
   logic second_q;
   assign rd_mux = (addr_i == bcc_pkg::ADDR_SECONDS) ? sec_count :
                   (addr_i == bcc_pkg::ADDR_MINUTES) ? min_count :
                   (addr_i == bcc_pkg::ADDR_HOURS) ? hour_count :
                   (addr_i == bcc_pkg::ADDR_WEEKDAY) ? weekday_onehot_q :
                   (addr_i == bcc_pkg::ADDR_DAY) ? day_count :
                   (addr_i == bcc_pkg::ADDR_MONTH) ? month_count :
                   (addr_i == bcc_pkg::ADDR_YEAR) ? year_count :
                   (addr_i == bcc_pkg::ADDR_CONTROL) ? {7'h00, stop_q} : 8'h00;

   // Read data register and a registered copy of the second tick
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         rdata_q <= 8'h00;
         second_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rd_i ? rd_mux : 8'h00;
         second_q <= sec_inc;
      end
   end
   assign rdata_o = rdata_q;
   assign second_tick_o = second_q;
endmodule : bcc_clock_calendar
`default_nettype wire

// ---- sim/bcc_clock_calendar_monitor.sv ----
// Port-level checker for the clock and calendar chain
`timescale 1ns/100ps
`default_nettype none
module bcc_clock_calendar_monitor (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic osc_tick_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic second_tick_o
);
   localparam int W = bcc_pkg::DIV_WIDTH;
   logic stop_q;
   logic [W-1:0] cnt_q;
   wire logic [4:0] rsel = {rd_i, addr_i};
   wire logic sec_wr = wr_i && addr_i == bcc_pkg::ADDR_SECONDS;
   wire logic full = osc_tick_i && !stop_q && !sec_wr && &cnt_q;
   // Shadow divider; stop holds it at zero so a restart counts a full second
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         stop_q <= 1'b1;
         cnt_q <= '0;
      end
      else
      begin
         if (wr_i && addr_i == bcc_pkg::ADDR_CONTROL)
            stop_q <= wdata_i[0];
         cnt_q <= (sec_wr || stop_q) ? '0 : cnt_q + W'(osc_tick_i);
      end
   end
   ////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   property p_tick; second_tick_o == $past(full); endproperty
   a_tick: assert property (p_tick) else $error("second pulse off");
   property p_stop; $past(stop_q) |-> !second_tick_o; endproperty
   a_stop: assert property (p_stop) else $error("counted while stopped");
   property p_ctrl; $past(rsel) == 5'h17 |-> rdata_o[0] == $past(stop_q); endproperty
   a_ctrl: assert property (p_ctrl) else $error("stop bit read wrong");
   property p_sec; $past(rsel) == 5'h10 |-> rdata_o <= 8'h60 && rdata_o[3:0] <= 4'h9; endproperty
   a_sec: assert property (p_sec) else $error("seconds out of range");
   property p_min; $past(rsel) == 5'h11 |-> rdata_o inside {[8'h00:8'h59]}; endproperty
   a_min: assert property (p_min) else $error("minutes out of range");
   property p_hour; $past(rsel) == 5'h12 |-> rdata_o inside {[8'h00:8'h23]}; endproperty
   a_hour: assert property (p_hour) else $error("hours out of range");
   property p_wday; $past(rsel) == 5'h13 |-> $onehot(rdata_o[6:0]); endproperty
   a_wday: assert property (p_wday) else $error("weekday not one-hot");
   property p_day; $past(rsel) == 5'h14 |-> rdata_o inside {[8'h01:8'h31]}; endproperty
   a_day: assert property (p_day) else $error("day out of range");
   property p_mon; $past(rsel) == 5'h15 |-> rdata_o inside {[8'h01:8'h12]}; endproperty
   a_mon: assert property (p_mon) else $error("month out of range");
   property p_year; $past(rsel) == 5'h16 |-> rdata_o[7:4] <= 4'h9 && rdata_o[3:0] <= 4'h9; endproperty
   a_year: assert property (p_year) else $error("year not BCD");
endmodule : bcc_clock_calendar_monitor
bind bcc_clock_calendar bcc_clock_calendar_monitor u_monitor (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .osc_tick_i(osc_tick_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .second_tick_o(second_tick_o));
`default_nettype wire

// ---- sim/bcc_clock_calendar_bench.sv ----
// Self-checking bench for the clock and calendar chain
`timescale 1ns/100ps
`default_nettype none
module bcc_clock_calendar_bench;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic osc_tick_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic second_tick_o;
   int fails = 0;
   int checks_done = 0;
   int seed = 26;
   int pulses = 0;
   int secs_exp = 0;
   int s, m, h, wd, d, mo, y, k;
   always #25 clock_i = ~clock_i;
   // Count second pulses; an unknown level is not counted and so shows up
   always @(posedge clock_i)
      if (second_tick_o === 1'b1)
         pulses++;
   bcc_clock_calendar dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .osc_tick_i(osc_tick_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .second_tick_o(second_tick_o));
   ////////////////////////////////////////////////////////
   function automatic logic [7:0] bcd(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction : bcd
   function automatic int mdays(input int mon, input int yr);
      if (mon == 2)
         return (yr % 4 == 0) ? 29 : 28;
      return (mon == 4 || mon == 6 || mon == 9 || mon == 11) ? 30 : 31;
   endfunction : mdays
   task automatic model_set(input int hh, mm, ss, w, dd, mn, yy);
      h = hh;
      m = mm;
      s = ss;
      wd = w;
      d = dd;
      mo = mn;
      y = yy;
   endtask : model_set
   // One second of the model; carries ripple all the way up at once
   task automatic model_second();
      secs_exp++;
      s = s + 1;
      if (s <= 59) return;
      s = 0;
      m = (m + 1) % 60;
      if (m != 0) return;
      h = (h + 1) % 24;
      if (h != 0) return;
      wd = (wd == 64) ? 1 : wd * 2;
      d = d + 1;
      if (d <= mdays(mo, y)) return;
      d = 1;
      mo = mo % 12 + 1;
      if (mo != 1) return;
      y = (y + 1) % 100;
   endtask : model_second
   // Bus cycle; the idle cycle after it keeps strobes from double assignment
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] dat,
      output logic [7:0] q);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= dat;
      @(posedge clock_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1 q = rdata_o;
      @(posedge clock_i);
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [7:0] dat);
      logic [7:0] junk;
      bus(1'b1, a, dat, junk);
   endtask : wr
   task automatic chk(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      checks_done++;
      if ((q & mask) !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, q & mask, exp);
      end
   endtask : chk
   // Every model second must have shown exactly one second pulse
   task automatic chk_tick();
      checks_done++;
      if (pulses !== secs_exp)
      begin
         fails++;
         $display("[FAIL] t=%0t pulses=%h exp=%h", $time, pulses, secs_exp);
      end
   endtask : chk_tick
   task automatic check_all();
      logic [7:0] e [7] = '{bcd(s), bcd(m), bcd(h), 8'(wd), bcd(d), bcd(mo), bcd(y)};
      for (int i = 0; i < 7; i++)
         chk(4'(i), 8'hff, e[i]);
      chk_tick();
   endtask : check_all
   // Host writes valid values, weekday included, seconds last
   task automatic put(input int hh, mm, ss, w, dd, mn, yy);
      logic [7:0] v [7] = '{bcd(ss), bcd(mm), bcd(hh), 8'(w), bcd(dd), bcd(mn), bcd(yy)};
      model_set(hh, mm, ss, w, dd, mn, yy);
      for (int i = 6; i >= 0; i--)
         wr(4'(i), v[i]);
   endtask : put
   // Irregular tick spacing stresses the divider
   task automatic ticks(input int n);
      repeat (n)
      begin
         osc_tick_i <= 1'b1;
         @(posedge clock_i);
         osc_tick_i <= 1'b0;
         repeat (1 + ($random(seed) & 1)) @(posedge clock_i);
      end
   endtask : ticks
   task automatic sec();
      ticks(1024);
      model_second();
      check_all();
   endtask : sec
   task automatic close_out();
      if (fails == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      model_set(0, 0, 0, 1, 1, 1, 0);
      check_all();
      chk(bcc_pkg::ADDR_CONTROL, 8'h01, 8'h01);
      chk(4'hf, 8'hff, 8'h00);
      ticks(1100);
      check_all();
      wr(bcc_pkg::ADDR_CONTROL, 8'h00);
      sec();
      ticks(500);
      put(1, 2, 3, 2, 4, 5, 6);
      ticks(1023);
      check_all();
      ticks(1);
      model_second();
      check_all();
      k = $unsigned($random(seed)) % 59;
      put(10, k, 60, 8, 12, 7, 25);
      sec();
      for (int i = 1; i <= 12; i++)
      begin
         put(23, 59, 59, 64, mdays(i, 3), i, 3);
         sec();
      end
      put(23, 59, 59, 1, 28, 2, 4);
      sec();
      put(23, 59, 59, 4, 29, 2, 0);
      sec();
      put(23, 59, 59, 32, 31, 12, 99);
      sec();
      put(23, 59, 59, 2, 28, 2, 0);
      sec();
      // Host treats this 00 as a common century and moves 29 Feb on to 1 Mar
      put(0, 0, 0, 4, 1, 3, 0);
      check_all();
      close_out();
   end
   // Watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (100000) @(posedge clock_i);
      fails++;
      close_out();
   end
endmodule : bcc_clock_calendar_bench
`default_nettype wire
